// ==== pmc_ctrl.sv ====
// power management control register with phy reset timing and mac soft reset
`timescale 1ns/1ps

// ============================================================================
module pmc_ctrl #(
  parameter logic [pmc_pkg::PMC_CNT_W-1:0] PHY_HOLD_MIN_CYC = pmc_pkg::PMC_CNT_W'(pmc_pkg::PMC_PHY_HOLD_MIN_CYC),
  parameter logic [pmc_pkg::PMC_CNT_W-1:0] PHY_HOLD_EXT_CYC = pmc_pkg::PMC_CNT_W'(pmc_pkg::PMC_PHY_HOLD_EXT_CYC)
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // device resets and protection
  input wire logic device_reset,
  input wire logic reset_protect,
  // wake and resume events
  input wire logic lpi_wake_event,
  input wire logic resume_done,
  input wire logic resume_remote,
  output logic lpi_wake_request,
  output pmc_pkg::pmc_resume_clr_t resume_clr,
  // phy reset sequencing
  input wire logic phy_reset_request,
  output logic phy_in_reset,
  output logic analog_ref_enable,
  // mac domain resets
  input wire logic rx_clk_running,
  input wire logic tx_clk_running,
  output logic mac_rx_reset,
  output logic mac_tx_reset,
  // power state controls
  output logic oscillator_keep_alive,
  output pmc_pkg::pmc_susp_t suspend_select
);

  // ==========================================================================
  // register image
  pmc_pkg::pmc_ctl_t ctl;
  logic sel_ok;
  logic wr_fire;
  logic remote_resume;
  logic [1:0] rx_run_sync;
  logic [1:0] tx_run_sync;
  logic [pmc_pkg::PMC_CNT_W-1:0] hold_cnt;
  logic [pmc_pkg::PMC_CNT_W-1:0] hold_limit;

  typedef enum logic {PMC_PHY_RUN, PMC_PHY_HOLD} pmc_phy_st_t;
  pmc_phy_st_t phy_st;
  pmc_phy_st_t next_phy_st;

  // pack the struct into the bus word, reserved bits zero
  function automatic logic [31:0] pmc_word(input pmc_pkg::pmc_ctl_t c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[pmc_pkg::PMC_SKIP_REF_BIT] = c.skip_analog_ref_settle;
    w[pmc_pkg::PMC_OSC_KEEP_BIT] = c.oscillator_keep_alive;
    w[pmc_pkg::PMC_LPI_EN_BIT] = c.lpi_wake_enable;
    w[pmc_pkg::PMC_LPI_STS_BIT] = c.lpi_wake_status;
    w[pmc_pkg::PMC_MAC_DOMAIN_SOFT_RESET_BIT] = c.mac_domain_soft_reset;
    w[pmc_pkg::PMC_RES_STS_BIT] = c.resume_clears_wake_status;
    w[pmc_pkg::PMC_RES_EN_BIT] = c.resume_clears_wake_enables;
    w[pmc_pkg::PMC_SUSP_LSB +: 2] = c.suspend_select;
    return w;
  endfunction : pmc_word

  // ==========================================================================
  // apb decode: zero wait states, unmapped address answers with slverr
  assign sel_ok = (paddr == pmc_pkg::PMC_CTL_OFFSET);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~sel_ok;
  assign wr_fire = psel & penable & pwrite & sel_ok;
  assign remote_resume = resume_done & resume_remote;

  // read data captured in the setup cycle so it stands through the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= sel_ok ? pmc_word(ctl) : 32'h0000_0000;
    end
  end

  // ==========================================================================
  // protected fields: only power-on clears them while protection is on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl.skip_analog_ref_settle <= pmc_pkg::PMC_SKIP_REF_RST;
      ctl.oscillator_keep_alive <= pmc_pkg::PMC_OSC_KEEP_RST;
    end else if (device_reset && !reset_protect) begin
      ctl.skip_analog_ref_settle <= pmc_pkg::PMC_SKIP_REF_RST;
      ctl.oscillator_keep_alive <= pmc_pkg::PMC_OSC_KEEP_RST;
    end else if (wr_fire) begin
      ctl.skip_analog_ref_settle <= pwdata[pmc_pkg::PMC_SKIP_REF_BIT];
      ctl.oscillator_keep_alive <= pwdata[pmc_pkg::PMC_OSC_KEEP_BIT];
    end
  end

  // plain read/write controls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl.mac_domain_soft_reset <= pmc_pkg::PMC_MAC_DOMAIN_SOFT_RESET_RST;
      ctl.resume_clears_wake_status <= pmc_pkg::PMC_RES_STS_RST;
      ctl.resume_clears_wake_enables <= pmc_pkg::PMC_RES_EN_RST;
      ctl.suspend_select <= pmc_pkg::pmc_susp_t'(pmc_pkg::PMC_SUSP_RST);
    end else if (device_reset) begin
      ctl.mac_domain_soft_reset <= pmc_pkg::PMC_MAC_DOMAIN_SOFT_RESET_RST;
      ctl.resume_clears_wake_status <= pmc_pkg::PMC_RES_STS_RST;
      ctl.resume_clears_wake_enables <= pmc_pkg::PMC_RES_EN_RST;
      ctl.suspend_select <= pmc_pkg::pmc_susp_t'(pmc_pkg::PMC_SUSP_RST);
    end else if (wr_fire) begin
      ctl.mac_domain_soft_reset <= pwdata[pmc_pkg::PMC_MAC_DOMAIN_SOFT_RESET_BIT];
      ctl.resume_clears_wake_status <= pwdata[pmc_pkg::PMC_RES_STS_BIT];
      ctl.resume_clears_wake_enables <= pwdata[pmc_pkg::PMC_RES_EN_BIT];
      ctl.suspend_select <= pmc_pkg::pmc_susp_t'(pwdata[pmc_pkg::PMC_SUSP_LSB +: 2]);
    end
  end

  // lpi wake enable: software written, dropped by a remote resume
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl.lpi_wake_enable <= pmc_pkg::PMC_LPI_EN_RST;
    end else if (device_reset) begin
      ctl.lpi_wake_enable <= pmc_pkg::PMC_LPI_EN_RST;
    end else if (remote_resume && ctl.resume_clears_wake_enables) begin
      ctl.lpi_wake_enable <= 1'b0;
    end else if (wr_fire) begin
      ctl.lpi_wake_enable <= pwdata[pmc_pkg::PMC_LPI_EN_BIT];
    end
  end

  // lpi wake status: a new event beats any clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl.lpi_wake_status <= pmc_pkg::PMC_LPI_STS_RST;
    end else if (lpi_wake_event) begin
      ctl.lpi_wake_status <= 1'b1;
    end else if (device_reset) begin
      ctl.lpi_wake_status <= pmc_pkg::PMC_LPI_STS_RST;
    end else if (remote_resume && ctl.resume_clears_wake_status) begin
      ctl.lpi_wake_status <= 1'b0;
    end else if (wr_fire && pwdata[pmc_pkg::PMC_LPI_STS_BIT]) begin
      ctl.lpi_wake_status <= 1'b0;
    end
  end

  // ==========================================================================
  // wake and resume outputs toward the rest of the device
  assign lpi_wake_request = ctl.lpi_wake_status & ctl.lpi_wake_enable;

  // one-cycle clear pulses for the wake control/status registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resume_clr <= '0;
    end else begin
      resume_clr.wake_status_clear <= remote_resume & ctl.resume_clears_wake_status;
      resume_clr.wake_cause_hi_clear <= remote_resume & ctl.resume_clears_wake_status;
      resume_clr.wake_enable_clear <= remote_resume & ctl.resume_clears_wake_enables;
    end
  end

  // crystal and suspend controls go straight out of the register
  assign oscillator_keep_alive = ctl.oscillator_keep_alive;
  assign suspend_select = ctl.suspend_select;

  // ==========================================================================
  // phy reset hold: short when reference stays on, long for ref settling
  assign hold_limit = ctl.skip_analog_ref_settle ? PHY_HOLD_MIN_CYC : PHY_HOLD_EXT_CYC;

  always_comb begin
    next_phy_st = phy_st;
    unique case (phy_st)
      PMC_PHY_RUN: begin
        if (phy_reset_request) begin
          next_phy_st = PMC_PHY_HOLD;
        end
      end
      PMC_PHY_HOLD: begin
        if (hold_cnt >= hold_limit - 1'b1) begin
          next_phy_st = PMC_PHY_RUN;
        end
      end
    endcase
  end

  // requests during a hold are ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phy_st <= PMC_PHY_RUN;
      hold_cnt <= '0;
    end else begin
      phy_st <= next_phy_st;
      hold_cnt <= (phy_st == PMC_PHY_HOLD) ? hold_cnt + 1'b1 : '0;
    end
  end

  assign phy_in_reset = (phy_st == PMC_PHY_HOLD);
  // reference kept on during reset only when asked, trading power for speed
  assign analog_ref_enable = ~phy_in_reset | ctl.skip_analog_ref_settle;

  // ==========================================================================
  // mac domain resets: clock-running flags arrive from other domains
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_run_sync <= 2'h0;
      tx_run_sync <= 2'h0;
    end else begin
      rx_run_sync <= {rx_run_sync[0], rx_clk_running};
      tx_run_sync <= {tx_run_sync[0], tx_clk_running};
    end
  end

  // assert at once, release only once the domain clock is seen running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mac_rx_reset <= 1'b1;
      mac_tx_reset <= 1'b1;
    end else begin
      mac_rx_reset <= ctl.mac_domain_soft_reset | (mac_rx_reset & ~rx_run_sync[1]);
      mac_tx_reset <= ctl.mac_domain_soft_reset | (mac_tx_reset & ~tx_run_sync[1]);
    end
  end

  // ==========================================================================
  // checks
  sequence s_remote_resume_sts;
    remote_resume && ctl.resume_clears_wake_status && !lpi_wake_event;
  endsequence

  sequence s_hold_start;
    !phy_in_reset && phy_reset_request;
  endsequence

  sequence s_unprotected_reset;
    device_reset && !reset_protect;
  endsequence

  skip_ref_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    phy_in_reset && ctl.skip_analog_ref_settle |-> analog_ref_enable)
    else $error("reference dropped while skip set");

  // a hold with the reference off runs the full long count, whatever its setting
  ref_settle_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(phy_in_reset) && !$past(ctl.skip_analog_ref_settle) |-> $past(hold_cnt) == PHY_HOLD_EXT_CYC - 1'b1)
    else $error("hold shorter than reference settle");

  hold_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    phy_in_reset && ($past(hold_cnt) == hold_cnt) |-> hold_cnt == '0)
    else $error("hold counter stalled");

  protect_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    device_reset && reset_protect && !wr_fire |=> $stable(ctl.oscillator_keep_alive))
    else $error("protected field lost on reset");

  lpi_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    lpi_wake_request |-> ctl.lpi_wake_enable && ctl.lpi_wake_status)
    else $error("wake request without enable");

  lpi_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    lpi_wake_event |=> ctl.lpi_wake_status)
    else $error("lpi status missed event");

  resume_sts_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_remote_resume_sts |=> !ctl.lpi_wake_status ##0 resume_clr.wake_cause_hi_clear)
    else $error("remote resume left status set");

  host_resume_a: assert property (@(posedge pclk) disable iff (!presetn)
    resume_done && !resume_remote && !wr_fire && !device_reset |=>
      $stable(ctl.lpi_wake_enable) && !resume_clr.wake_status_clear && !resume_clr.wake_enable_clear)
    else $error("host resume touched wake bits");

  resume_en_a: assert property (@(posedge pclk) disable iff (!presetn)
    remote_resume && ctl.resume_clears_wake_enables |=> !ctl.lpi_wake_enable && resume_clr.wake_enable_clear)
    else $error("remote resume left enables");

  mac_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctl.mac_domain_soft_reset |=> mac_rx_reset && mac_tx_reset)
    else $error("mac domain released while soft reset high");

  mac_release_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(mac_rx_reset) |-> $past(rx_run_sync[1]))
    else $error("mac rx released without clock");

  w1c_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_fire && !pwdata[pmc_pkg::PMC_LPI_STS_BIT] && ctl.lpi_wake_status |=> ctl.lpi_wake_status)
    else $error("write of zero cleared lpi status");

  reserved_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite |=> prdata[31:16] == 16'h0000 && prdata[10] == 1'b0)
    else $error("reserved bits read nonzero");

  // further checks on hold start, resets, resume policy and suspend field
  hold_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_hold_start |=> phy_in_reset)
    else $error("phy hold did not start");

  protect_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_unprotected_reset |=> !ctl.skip_analog_ref_settle && !ctl.oscillator_keep_alive)
    else $error("unprotected reset kept power fields");

  // with the status policy off a resume must not touch any status
  resume_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    resume_done && !ctl.resume_clears_wake_status && !lpi_wake_event && !wr_fire && !device_reset |=>
      $stable(ctl.lpi_wake_status) && !resume_clr.wake_status_clear && !resume_clr.wake_cause_hi_clear)
    else $error("resume cleared status with policy off");

  mac_tx_release_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(mac_tx_reset) |-> $past(tx_run_sync[1]))
    else $error("mac tx released without clock");

  // a register write lands in the suspend field on the next edge
  suspend_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_fire && !device_reset |=> suspend_select == $past(pwdata[pmc_pkg::PMC_SUSP_LSB +: 2]))
    else $error("suspend field not written");

endmodule : pmc_ctrl

// ==== pmc_ctrl_tb.sv ====
// self-checking testbench for the power management control register
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
  $display("Error at %0t: got %0h expected %0h", $time, g, e); end end

module pmc_ctrl_tb;
  // ==========================================================================
  // signals
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, shadow, rd;
  logic pready, pslverr, err, device_reset = 0, reset_protect = 0;
  logic lpi_wake_event = 0, resume_done = 0, resume_remote = 0, lpi_wake_request;
  logic phy_reset_request = 0, phy_in_reset, analog_ref_enable, ref_seen;
  logic rx_clk_running = 1, tx_clk_running = 1, mac_rx_reset, mac_tx_reset;
  logic oscillator_keep_alive;
  pmc_pkg::pmc_resume_clr_t resume_clr;
  pmc_pkg::pmc_susp_t suspend_select;
  int mismatches = 0, tests_run = 0, cnt;
  integer seed = 32'ha5182013;
  localparam logic [11:0] OFF = pmc_pkg::PMC_CTL_OFFSET;
  localparam logic [31:0] RW_MASK = 32'h0000_eb60;
  // short hold counts keep the run brief
  localparam logic [pmc_pkg::PMC_CNT_W-1:0] MIN_C = 20;
  localparam logic [pmc_pkg::PMC_CNT_W-1:0] EXT_C = 40;

  always #10 pclk = ~pclk;

  pmc_ctrl #(.PHY_HOLD_MIN_CYC(MIN_C), .PHY_HOLD_EXT_CYC(EXT_C)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .device_reset(device_reset), .reset_protect(reset_protect),
    .lpi_wake_event(lpi_wake_event), .resume_done(resume_done), .resume_remote(resume_remote),
    .lpi_wake_request(lpi_wake_request), .resume_clr(resume_clr),
    .phy_reset_request(phy_reset_request), .phy_in_reset(phy_in_reset),
    .analog_ref_enable(analog_ref_enable), .rx_clk_running(rx_clk_running),
    .tx_clk_running(tx_clk_running), .mac_rx_reset(mac_rx_reset), .mac_tx_reset(mac_tx_reset),
    .oscillator_keep_alive(oscillator_keep_alive), .suspend_select(suspend_select));

  // ==========================================================================
  // expectation: rw bits follow the write, status bit clears on a written one
  function automatic logic [31:0] exp_write(input logic [31:0] old, input logic [31:0] w);
    return (w & RW_MASK) | (old & ~w & 32'h0000_1000);
  endfunction : exp_write

  // ==========================================================================
  // apb master: request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    `CHK(pready, 1'b1)
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr_reg(input logic [31:0] d);
    apb(1'b1, OFF, d, rd, err);
    shadow = exp_write(shadow, d);
  endtask : wr_reg

  task automatic chk_reg;
    apb(1'b0, OFF, 32'h0, rd, err);
    `CHK(rd, shadow)
  endtask : chk_reg

  // one-cycle event pulse: 0 lpi wake, 1 device reset
  task automatic pulse(input int which);
    @(posedge pclk);
    if (which == 0) lpi_wake_event <= 1'b1; else device_reset <= 1'b1;
    @(posedge pclk);
    lpi_wake_event <= 1'b0;
    device_reset <= 1'b0;
  endtask : pulse

  // phy hold length, a second request mid-hold must be ignored
  task automatic phy_hold;
    @(posedge pclk);
    phy_reset_request <= 1'b1;
    @(posedge pclk);
    phy_reset_request <= 1'b0;
    #1 ref_seen = analog_ref_enable;
    cnt = 0;
    while (phy_in_reset === 1'b1 && cnt < 200) begin
      @(posedge pclk);
      phy_reset_request <= (cnt == 3);
      #1 cnt++;
    end
  endtask : phy_hold

  // resume with chosen origin and clear policies, status pre-set by an event
  task automatic resume_case(input logic rem, input logic b9, input logic b8);
    wr_reg(32'h0000_2000 | {22'h0, b9, b8, 8'h00});
    pulse(0);
    shadow[12] = 1'b1;
    @(posedge pclk);
    resume_done <= 1'b1;
    resume_remote <= rem;
    @(posedge pclk);
    resume_done <= 1'b0;
    #1 `CHK(resume_clr, {rem & b9, rem & b9, rem & b8})
    @(posedge pclk);
    #1 `CHK(resume_clr, 3'b000)
    if (rem & b9) shadow[12] = 1'b0;
    if (rem & b8) shadow[13] = 1'b0;
    chk_reg;
  endtask : resume_case

  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  // ==========================================================================
  // watchdog, well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    $display("Error at %0t: watchdog expired", $time);
    results;
  end

  // ==========================================================================
  // main sequence
  initial begin
    logic [31:0] w;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    shadow = pmc_pkg::PMC_CTL_RESET;
    repeat (5) @(posedge pclk);
    chk_reg;
    `CHK(suspend_select, pmc_pkg::PMC_DEEP_SUSPEND_STATE)
    `CHK({mac_rx_reset, mac_tx_reset}, 2'b00)
    $display("reset values done");
    wr_reg(32'hffff_efff);
    chk_reg;
    `CHK(oscillator_keep_alive, 1'b1)
    `CHK({mac_rx_reset, mac_tx_reset}, 2'b11)
    apb(1'b1, 12'h018, 32'h0, rd, err);
    `CHK(err, 1'b1)
    apb(1'b0, 12'h018, 32'h0, rd, err);
    `CHK(rd, 32'h0)
    chk_reg;
    for (int i = 0; i < 4; i++) begin
      wr_reg({25'h0, i[1:0], 5'h00});
      #1 `CHK(suspend_select, i[1:0])
    end
    $display("access kinds done");
    for (int i = 0; i < 24; i++) begin
      w = $random(seed);
      w[12] = 1'b0;
      wr_reg(w);
      chk_reg;
      `CHK({oscillator_keep_alive, suspend_select}, {shadow[14], shadow[6:5]})
    end
    $display("random writes done");
    wr_reg(32'h0);
    @(posedge pclk);
    rx_clk_running <= 1'b0;
    wr_reg(32'h0000_0800);
    repeat (2) @(posedge pclk);
    #1 `CHK({mac_rx_reset, mac_tx_reset}, 2'b11)
    wr_reg(32'h0);
    repeat (5) @(posedge pclk);
    #1 `CHK({mac_rx_reset, mac_tx_reset}, 2'b10)
    rx_clk_running <= 1'b1;
    repeat (5) @(posedge pclk);
    #1 `CHK(mac_rx_reset, 1'b0)
    $display("mac soft reset done");
    phy_hold;
    `CHK(cnt, int'(EXT_C))
    `CHK(ref_seen, 1'b0)
    wr_reg(32'h0000_8000);
    phy_hold;
    `CHK(cnt, int'(MIN_C))
    `CHK(ref_seen, 1'b1)
    $display("phy hold done");
    wr_reg(32'h0000_2000);
    pulse(0);
    shadow[12] = 1'b1;
    chk_reg;
    `CHK(lpi_wake_request, 1'b1)
    wr_reg(32'h0000_0000);
    chk_reg;
    `CHK(lpi_wake_request, 1'b0)
    wr_reg(32'h0000_1000);
    chk_reg;
    pulse(0);
    shadow[12] = 1'b1;
    chk_reg;
    wr_reg(32'h0000_1000);
    $display("lpi wake done");
    resume_case(1'b0, 1'b1, 1'b1);
    resume_case(1'b1, 1'b0, 1'b0);
    resume_case(1'b1, 1'b1, 1'b0);
    resume_case(1'b1, 1'b0, 1'b1);
    resume_case(1'b1, 1'b1, 1'b1);
    $display("resume policies done");
    wr_reg(32'h0000_e000);
    reset_protect <= 1'b1;
    pulse(1);
    shadow = pmc_pkg::PMC_CTL_RESET | 32'h0000_c000;
    chk_reg;
    reset_protect <= 1'b0;
    pulse(1);
    shadow = pmc_pkg::PMC_CTL_RESET;
    chk_reg;
    $display("device reset done");
    results;
  end
endmodule : pmc_ctrl_tb

// ==== pmc_pkg.sv ====
// package for the power management control register block
package pmc_pkg;
  // ==========================================================================
  // register map
  localparam logic [11:0] PMC_CTL_OFFSET = 12'h014;
  localparam logic [31:0] PMC_CTL_RESET = 32'h0000_0140;

  // ==========================================================================
  // field positions
  localparam int PMC_SKIP_REF_BIT = 15;
  localparam int PMC_OSC_KEEP_BIT = 14;
  localparam int PMC_LPI_EN_BIT = 13;
  localparam int PMC_LPI_STS_BIT = 12;
  localparam int PMC_MAC_DOMAIN_SOFT_RESET_BIT = 11;
  localparam int PMC_RES_STS_BIT = 9;
  localparam int PMC_RES_EN_BIT = 8;
  localparam int PMC_SUSP_LSB = 5;

  // ==========================================================================
  // field reset values
  localparam logic PMC_SKIP_REF_RST = 1'b0;
  localparam logic PMC_OSC_KEEP_RST = 1'b0;
  localparam logic PMC_LPI_EN_RST = 1'b0;
  localparam logic PMC_LPI_STS_RST = 1'b0;
  localparam logic PMC_MAC_DOMAIN_SOFT_RESET_RST = 1'b0;
  localparam logic PMC_RES_STS_RST = 1'b0;
  localparam logic PMC_RES_EN_RST = 1'b1;
  localparam logic [1:0] PMC_SUSP_RST = 2'h2;

  // ==========================================================================
  // timing
  localparam int PMC_CLK_KHZ = 50000;
  localparam int PMC_PHY_HOLD_MIN_MS = 4;
  localparam int PMC_PHY_HOLD_EXT_MS = 128;
  localparam int PMC_REF_SETTLE_MS = 100;
  localparam int PMC_PHY_HOLD_MIN_CYC = PMC_PHY_HOLD_MIN_MS * PMC_CLK_KHZ;
  localparam int PMC_PHY_HOLD_EXT_CYC = PMC_PHY_HOLD_EXT_MS * PMC_CLK_KHZ;
  localparam int PMC_REF_SETTLE_CYC = PMC_REF_SETTLE_MS * PMC_CLK_KHZ;
  localparam int PMC_CNT_W = 23;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    PMC_SUSPEND0, PMC_SUSPEND1, PMC_DEEP_SUSPEND_STATE, PMC_SUSPEND3
  } pmc_susp_t;

  typedef struct packed {
    logic skip_analog_ref_settle;
    logic oscillator_keep_alive;
    logic lpi_wake_enable;
    logic lpi_wake_status;
    logic mac_domain_soft_reset;
    logic resume_clears_wake_status;
    logic resume_clears_wake_enables;
    pmc_susp_t suspend_select;
  } pmc_ctl_t;

  // resume clear pulses toward the wake control/status registers
  typedef struct packed {
    logic wake_status_clear;
    logic wake_cause_hi_clear;
    logic wake_enable_clear;
  } pmc_resume_clr_t;
endpackage : pmc_pkg
